//--- verilog/serial_port_control.sv
// Purpose: Control register bank of the quad serial system-side port
// Assumes: Straps are asynchronous pins; data and speed inputs share ref_clk
// Notes: Straps are sampled once, a few cycles after reset release
//
// Functional notes
// [RULE_01] Writing one to bit 15 resets port machines; bit clears itself when done.
// [RULE_02] Bit 14 set loops internal transmit data back onto internal receive.
// [RULE_03] While loopback is on, the serial link is held down.
// [RULE_04] Serial mode zero: speed bits 6 and 13 read-only, showing resolved speed.
// [RULE_05] Serial mode one: speed bits writable; (6,13) 10 is 1000, 01 is 100.
// [RULE_06] Changing autoneg enable breaks link, restarts autoneg, sets bit 9.
// [RULE_07] Hardware reset loads autoneg enable from strap; software reset keeps it.
// [RULE_08] Hardware reset sets power down only if strap high and mode strap 101.
// [RULE_09] Power down bit set powers the port down; cleared returns to normal.
// [RULE_10] Writing one to bit 9 restarts autoneg; the bit clears itself.
// [RULE_11] Autoneg restarts after hardware reset, software reset and enable change.
// [RULE_12] Mode register bit 0 picks system (0) or media (1) serial mode.
// [RULE_13] Reserved bits ignore writes: bit 8 reads one, bits 10, 7, 5:0 zero.
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.

`timescale 1ns/1ns

module serial_port_control (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [11:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [11:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic autoneg_strap,
  input wire logic powerdown_strap,
  input wire logic [2:0] mode_strap,
  input wire logic [1:0] net_speed,
  input wire logic [7:0] txd,
  input wire logic tx_en,
  input wire logic [7:0] line_rxd,
  input wire logic line_rx_dv,
  output logic [7:0] rxd,
  output logic rx_dv,
  output logic port_sw_reset,
  output logic link_enable,
  output logic loopback_en,
  output logic port_powerdown,
  output logic autoneg_enable,
  output logic autoneg_restart,
  output logic [1:0] speed_sel,
  output logic media_mode
);

  // ==========================================================================
  // State

  typedef struct packed {
    logic an_strap_s1;
    logic an_strap_s2;
    logic pd_strap_s1;
    logic pd_strap_s2;
    logic [2:0] mode_strap_s1;
    logic [2:0] mode_strap_s2;
    serial_port_pkg::boot_e boot;
    logic [1:0] settle;
    logic loopback;
    logic speed_msb;
    logic speed_lsb;
    logic an_enable;
    logic powerdown;
    logic serial_mode;
    logic sw_start;
    logic an_start;
    logic link_permit;
    logic [7:0] rxd;
    logic rx_dv;
  } ctrl_s;

  ctrl_s state_reg;
  ctrl_s state_next;

  reg_bus_if bus ();

  logic sw_busy;
  logic sw_done;
  logic an_busy;
  logic an_done;
  logic ctrl_wr;
  logic mode_wr;
  logic [15:0] ctrl_view;
  logic [15:0] mode_view;
  logic [15:0] status_view;
  logic [15:0] ctrl_wval;
  logic [15:0] mode_wval;

  // ==========================================================================
  // Helpers

  // Byte-lane merge of a 16-bit register with the low half of a bus word
  function automatic logic [15:0] merge16(
    input logic [15:0] old_val,
    input logic [31:0] wdata,
    input logic [3:0] wstrb
  );
    logic [15:0] res;
    res = old_val;
    if (wstrb[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (wstrb[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction : merge16

  // Address match on the word, ignoring the byte offset inside it
  function automatic logic addr_hit(
    input logic [11:0] addr,
    input logic [11:0] offset
  );
    return addr[11:2] == offset[11:2];
  endfunction : addr_hit

  // ==========================================================================
  // Bus slave and timers

  axil_reg_slave u_slave (
    .ref_clk(ref_clk),
    .rst(rst),
    .s_axil_awaddr(s_axil_awaddr),
    .s_axil_awvalid(s_axil_awvalid),
    .s_axil_awready(s_axil_awready),
    .s_axil_wdata(s_axil_wdata),
    .s_axil_wstrb(s_axil_wstrb),
    .s_axil_wvalid(s_axil_wvalid),
    .s_axil_wready(s_axil_wready),
    .s_axil_bresp(s_axil_bresp),
    .s_axil_bvalid(s_axil_bvalid),
    .s_axil_bready(s_axil_bready),
    .s_axil_araddr(s_axil_araddr),
    .s_axil_arvalid(s_axil_arvalid),
    .s_axil_arready(s_axil_arready),
    .s_axil_rdata(s_axil_rdata),
    .s_axil_rresp(s_axil_rresp),
    .s_axil_rvalid(s_axil_rvalid),
    .s_axil_rready(s_axil_rready),
    .bus(bus.bus_side)
  );

  // Port reset window; machines are held while busy
  pulse_timer #(
    .CYCLES(serial_port_pkg::SW_RESET_CYCLES)
  ) u_sw_reset (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(state_reg.sw_start),
    .busy(sw_busy),
    .done(sw_done)
  );

  // Autoneg restart window; bit 9 reads one while it runs
  pulse_timer #(
    .CYCLES(serial_port_pkg::AN_RESTART_CYCLES)
  ) u_an_restart (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(state_reg.an_start),
    .busy(an_busy),
    .done(an_done)
  );

  // ==========================================================================
  // Register views

  always_comb begin
    ctrl_view = 16'h0000;
    ctrl_view[serial_port_pkg::CTRL_RESET_BIT] = sw_busy || state_reg.sw_start; // see [RULE_01]
    ctrl_view[serial_port_pkg::CTRL_LOOPBACK_BIT] = state_reg.loopback;
    ctrl_view[serial_port_pkg::CTRL_SPEED_LSB_BIT] = state_reg.speed_lsb;
    ctrl_view[serial_port_pkg::CTRL_AN_EN_BIT] = state_reg.an_enable;
    ctrl_view[serial_port_pkg::CTRL_POWERDOWN_STRAP_BIT] = state_reg.powerdown;
    ctrl_view[serial_port_pkg::CTRL_AN_RESTART_BIT] = an_busy || state_reg.an_start; // see [RULE_10]
    ctrl_view[serial_port_pkg::CTRL_RSVD_ONE_BIT] = serial_port_pkg::RSVD_ONE_VALUE; // see [RULE_13]
    ctrl_view[serial_port_pkg::CTRL_SPEED_MSB_BIT] = state_reg.speed_msb;
  end

  always_comb begin
    mode_view = 16'h0000;
    mode_view[serial_port_pkg::MODE_SERIAL_BIT] = state_reg.serial_mode;
  end

  always_comb begin
    status_view = 16'h0000;
    status_view[serial_port_pkg::STAT_LINK_PERMIT_BIT] = state_reg.link_permit;
    status_view[serial_port_pkg::STAT_SW_RESET_BIT] = sw_busy;
    status_view[serial_port_pkg::STAT_AN_BUSY_BIT] = an_busy;
    status_view[serial_port_pkg::STAT_STRAPS_LOADED_BIT] = state_reg.boot == serial_port_pkg::BOOT_RUN;
    status_view[serial_port_pkg::STAT_SPEED_LSB_BIT] = state_reg.speed_lsb;
    status_view[serial_port_pkg::STAT_SPEED_MSB_BIT] = state_reg.speed_msb;
  end

  // ==========================================================================
  // Read and write decode

  always_comb begin
    bus.rd_ok = 1'b1;
    bus.rd_data = 32'h0000_0000;
    if (addr_hit(bus.rd_addr, serial_port_pkg::CTRL_OFFSET)) begin
      bus.rd_data = {16'h0000, ctrl_view};
    end else if (addr_hit(bus.rd_addr, serial_port_pkg::MODE_OFFSET)) begin
      bus.rd_data = {16'h0000, mode_view};
    end else if (addr_hit(bus.rd_addr, serial_port_pkg::STATUS_OFFSET)) begin
      bus.rd_data = {16'h0000, status_view};
    end else begin
      bus.rd_ok = 1'b0;
    end
  end

  assign ctrl_wr = bus.wr_req && addr_hit(bus.wr_addr, serial_port_pkg::CTRL_OFFSET);
  assign mode_wr = bus.wr_req && addr_hit(bus.wr_addr, serial_port_pkg::MODE_OFFSET);
  assign bus.wr_ok = addr_hit(bus.wr_addr, serial_port_pkg::CTRL_OFFSET)
                  || addr_hit(bus.wr_addr, serial_port_pkg::MODE_OFFSET)
                  || addr_hit(bus.wr_addr, serial_port_pkg::STATUS_OFFSET);
  assign ctrl_wval = merge16(ctrl_view, bus.wr_data, bus.wr_strb);
  assign mode_wval = merge16(mode_view, bus.wr_data, bus.wr_strb);

  // ==========================================================================
  // Next state

  always_comb begin
    state_next = state_reg;
    state_next.sw_start = 1'b0;
    state_next.an_start = 1'b0;

    // Strap synchronisers
    state_next.an_strap_s1 = autoneg_strap;
    state_next.an_strap_s2 = state_reg.an_strap_s1;
    state_next.pd_strap_s1 = powerdown_strap;
    state_next.pd_strap_s2 = state_reg.pd_strap_s1;
    state_next.mode_strap_s1 = mode_strap;
    state_next.mode_strap_s2 = state_reg.mode_strap_s1;

    // Mode register
    if (mode_wr) begin
      state_next.serial_mode = mode_wval[serial_port_pkg::MODE_SERIAL_BIT]; // see [RULE_12]
    end

    // Control register writes; reserved bits are simply not stored
    if (ctrl_wr) begin
      state_next.loopback = ctrl_wval[serial_port_pkg::CTRL_LOOPBACK_BIT]; // see [RULE_02]
      state_next.powerdown = ctrl_wval[serial_port_pkg::CTRL_POWERDOWN_STRAP_BIT]; // see [RULE_09]
      if (state_reg.serial_mode) begin
        state_next.speed_msb = ctrl_wval[serial_port_pkg::CTRL_SPEED_MSB_BIT]; // see [RULE_05]
        state_next.speed_lsb = ctrl_wval[serial_port_pkg::CTRL_SPEED_LSB_BIT]; // see [RULE_05]
      end
      if (ctrl_wval[serial_port_pkg::CTRL_AN_EN_BIT] != state_reg.an_enable) begin
        state_next.an_enable = ctrl_wval[serial_port_pkg::CTRL_AN_EN_BIT];
        state_next.an_start = 1'b1; // see [RULE_06] [RULE_11]
      end
      // Self-clearing bits act only on a one written in their own byte lane
      if (bus.wr_strb[1] && bus.wr_data[serial_port_pkg::CTRL_AN_RESTART_BIT]) begin
        state_next.an_start = 1'b1; // see [RULE_10]
      end
      if (bus.wr_strb[1] && bus.wr_data[serial_port_pkg::CTRL_RESET_BIT]) begin
        state_next.sw_start = 1'b1; // see [RULE_01]
      end
    end

    // Software reset clears loopback, keeps the other fields
    if (state_next.sw_start) begin
      state_next.loopback = serial_port_pkg::LOOPBACK_RST; // see [RULE_07]
    end
    if (sw_done) begin
      state_next.an_start = 1'b1; // see [RULE_11]
    end

    // System mode tracks the resolved network speed
    if (!state_next.serial_mode) begin
      state_next.speed_msb = net_speed[1]; // see [RULE_04]
      state_next.speed_lsb = net_speed[0]; // see [RULE_04]
    end

    // Strap capture after the synchronisers have settled
    unique case (state_reg.boot)
      serial_port_pkg::BOOT_SETTLE: begin
        state_next.settle = state_reg.settle + 2'h1;
        if (state_reg.settle == serial_port_pkg::STRAP_SETTLE_CYCLES) begin
          state_next.boot = serial_port_pkg::BOOT_LOAD;
        end
      end
      serial_port_pkg::BOOT_LOAD: begin
        state_next.an_enable = state_reg.an_strap_s2; // see [RULE_07]
        state_next.powerdown = state_reg.pd_strap_s2
                            && (state_reg.mode_strap_s2 == serial_port_pkg::POWERDOWN_STRAP_MODE_STRAP); // see [RULE_08]
        state_next.an_start = 1'b1; // see [RULE_11]
        state_next.boot = serial_port_pkg::BOOT_RUN;
      end
      serial_port_pkg::BOOT_RUN: begin
        state_next.boot = serial_port_pkg::BOOT_RUN;
      end
      default: begin
        state_next.boot = serial_port_pkg::BOOT_SETTLE;
      end
    endcase

    // Link is held down by loopback, power down, reset and autoneg restart
    state_next.link_permit = !state_reg.loopback // see [RULE_03]
                          && !state_reg.powerdown // see [RULE_09]
                          && !sw_busy && !state_reg.sw_start
                          && !an_busy && !state_reg.an_start // see [RULE_06]
                          && (state_reg.boot == serial_port_pkg::BOOT_RUN);

    // Internal receive path: line data or looped transmit data
    if (state_reg.loopback) begin
      state_next.rxd = txd; // see [RULE_02]
      state_next.rx_dv = tx_en;
    end else begin
      state_next.rxd = line_rxd;
      state_next.rx_dv = line_rx_dv;
    end
  end

  // ==========================================================================
  // Registers

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.boot <= serial_port_pkg::BOOT_SETTLE;
      state_reg.loopback <= serial_port_pkg::LOOPBACK_RST;
      state_reg.speed_msb <= serial_port_pkg::SPEED_MSB_RST;
      state_reg.speed_lsb <= serial_port_pkg::SPEED_LSB_RST;
      state_reg.serial_mode <= serial_port_pkg::SERIAL_MODE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Outputs

  assign rxd = state_reg.rxd;
  assign rx_dv = state_reg.rx_dv;
  assign port_sw_reset = sw_busy; // see [RULE_01]
  assign link_enable = state_reg.link_permit;
  assign loopback_en = state_reg.loopback;
  assign port_powerdown = state_reg.powerdown;
  assign autoneg_enable = state_reg.an_enable;
  assign autoneg_restart = an_busy;
  assign speed_sel = {state_reg.speed_msb, state_reg.speed_lsb};
  assign media_mode = state_reg.serial_mode;

endmodule : serial_port_control

//--- verilog/serial_port_pkg.sv
// Purpose: Shared constants and types for the serial port control register block
// Assumes: 100 MHz ref_clk, AXI4-Lite register access with 32-bit data
// Notes: Offsets are byte addresses; every register holds 16 bits in the low half

package serial_port_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SW_RESET_TIME_NS = 200;
  localparam int unsigned SW_RESET_CYCLES = (SW_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned AN_RESTART_TIME_NS = 100;
  localparam int unsigned AN_RESTART_CYCLES = (AN_RESTART_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

  // ==========================================================================
  // Register map
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] MODE_OFFSET = 12'h004;
  localparam logic [11:0] STATUS_OFFSET = 12'h008;

  // Control register fields
  localparam int unsigned CTRL_RESET_BIT = 15;
  localparam int unsigned CTRL_LOOPBACK_BIT = 14;
  localparam int unsigned CTRL_SPEED_LSB_BIT = 13;
  localparam int unsigned CTRL_AN_EN_BIT = 12;
  localparam int unsigned CTRL_POWERDOWN_STRAP_BIT = 11;
  localparam int unsigned CTRL_AN_RESTART_BIT = 9;
  localparam int unsigned CTRL_RSVD_ONE_BIT = 8;
  localparam int unsigned CTRL_SPEED_MSB_BIT = 6;

  // Mode and status fields
  localparam int unsigned MODE_SERIAL_BIT = 0;
  localparam int unsigned STAT_LINK_PERMIT_BIT = 0;
  localparam int unsigned STAT_SW_RESET_BIT = 1;
  localparam int unsigned STAT_AN_BUSY_BIT = 2;
  localparam int unsigned STAT_STRAPS_LOADED_BIT = 3;
  localparam int unsigned STAT_SPEED_LSB_BIT = 4;
  localparam int unsigned STAT_SPEED_MSB_BIT = 5;

  // ==========================================================================
  // Reset values
  localparam logic LOOPBACK_RST = 1'h0;
  localparam logic SPEED_MSB_RST = 1'h1;
  localparam logic SPEED_LSB_RST = 1'h0;
  localparam logic SERIAL_MODE_RST = 1'h0;
  localparam logic RSVD_ONE_VALUE = 1'h1;
  localparam logic [2:0] POWERDOWN_STRAP_MODE_STRAP = 3'h5;

  // ==========================================================================
  // Bus answers and start-up sequence
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    BOOT_SETTLE,
    BOOT_LOAD,
    BOOT_RUN
  } boot_e;

endpackage : serial_port_pkg

//--- verilog/reg_bus_if.sv
// Purpose: Carrier for register accesses between the bus slave and the register bank
// Assumes: One clock; requests are single-cycle pulses
// Notes: wr_ok and rd_ok tell the slave whether the address is mapped

`timescale 1ns/1ns

interface reg_bus_if;
  logic wr_req;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic rd_req;
  logic [11:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;

  modport bus_side (
    output wr_req, wr_addr, wr_data, wr_strb, rd_req, rd_addr,
    input wr_ok, rd_data, rd_ok
  );

  modport reg_side (
    input wr_req, wr_addr, wr_data, wr_strb, rd_req, rd_addr,
    output wr_ok, rd_data, rd_ok
  );
endinterface : reg_bus_if

//--- verilog/pulse_timer.sv
// Purpose: Busy window of a fixed number of cycles with a done pulse at its end
// Assumes: start is a one-cycle pulse from the same clock
// Notes: A start while busy reloads the count

`timescale 1ns/1ns

module pulse_timer #(
  parameter int unsigned CYCLES = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  output logic busy,
  output logic done
);

  localparam int unsigned CNT_W = $clog2(CYCLES + 1);

  typedef struct packed {
    logic busy;
    logic done;
    logic [CNT_W-1:0] cnt;
  } timer_s;

  timer_s state_reg;
  timer_s state_next;

  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    if (start) begin
      state_next.busy = 1'b1;
      state_next.cnt = CNT_W'(CYCLES - 1);
    end else if (state_reg.busy) begin
      if (state_reg.cnt == '0) begin
        state_next.busy = 1'b0;
        state_next.done = 1'b1;
      end else begin
        state_next.cnt = state_reg.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign busy = state_reg.busy;
  assign done = state_reg.done;

endmodule : pulse_timer

//--- verilog/axil_reg_slave.sv
// Purpose: AXI4-Lite slave that turns bus transfers into register requests
// Assumes: One write and one read outstanding at most
// Notes: Write answers one cycle after both address and data are held

`timescale 1ns/1ns

module axil_reg_slave (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [11:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [11:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  reg_bus_if.bus_side bus
);

  typedef struct packed {
    logic aw_held;
    logic [11:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } slave_s;

  slave_s state_reg;
  slave_s state_next;

  assign s_axil_awready = !state_reg.aw_held && !state_reg.bvalid;
  assign s_axil_wready = !state_reg.w_held && !state_reg.bvalid;
  assign s_axil_arready = !state_reg.rvalid;

  assign bus.wr_req = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
  assign bus.wr_addr = state_reg.awaddr;
  assign bus.wr_data = state_reg.wdata;
  assign bus.wr_strb = state_reg.wstrb;
  assign bus.rd_req = s_axil_arvalid && !state_reg.rvalid;
  assign bus.rd_addr = s_axil_araddr;

  always_comb begin
    state_next = state_reg;
    // ========================================================================
    // Write channels
    if (s_axil_awvalid && s_axil_awready) begin
      state_next.aw_held = 1'b1;
      state_next.awaddr = s_axil_awaddr;
    end
    if (s_axil_wvalid && s_axil_wready) begin
      state_next.w_held = 1'b1;
      state_next.wdata = s_axil_wdata;
      state_next.wstrb = s_axil_wstrb;
    end
    if (bus.wr_req) begin
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = bus.wr_ok ? serial_port_pkg::RESP_OKAY : serial_port_pkg::RESP_DECERR;
    end else if (state_reg.bvalid && s_axil_bready) begin
      state_next.bvalid = 1'b0;
    end
    // ========================================================================
    // Read channels
    if (bus.rd_req) begin
      state_next.rvalid = 1'b1;
      state_next.rdata = bus.rd_ok ? bus.rd_data : 32'h0000_0000;
      state_next.rresp = bus.rd_ok ? serial_port_pkg::RESP_OKAY : serial_port_pkg::RESP_DECERR;
    end else if (state_reg.rvalid && s_axil_rready) begin
      state_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign s_axil_bvalid = state_reg.bvalid;
  assign s_axil_bresp = state_reg.bresp;
  assign s_axil_rvalid = state_reg.rvalid;
  assign s_axil_rdata = state_reg.rdata;
  assign s_axil_rresp = state_reg.rresp;

endmodule : axil_reg_slave

//--- test/serial_port_control_checker.sv
// Purpose: Port checks of the serial port control bank
// Assumes: One ref_clk domain, synchronous rst
// Notes: Bound from the bench
`timescale 1ns/1ns
module serial_port_control_checker (
  input wire logic ref_clk, rst, tx_en, rx_dv, link_enable, loopback_en,
  input wire logic port_powerdown, autoneg_enable, autoneg_restart, port_sw_reset, media_mode,
  input wire logic [7:0] txd, rxd,
  input wire logic [1:0] net_speed, speed_sel
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_an_run; autoneg_restart [*8]; endsequence
  property p_lb_data; loopback_en |=> rxd == $past(txd) && rx_dv == $past(tx_en); endproperty
  a_lb_data: assert property (p_lb_data) else $error("loopback data");
  property p_link_down; loopback_en || port_powerdown || port_sw_reset |=> !link_enable; endproperty
  a_link_down: assert property (p_link_down) else $error("link not down");
  property p_an_link; autoneg_restart |=> !link_enable; endproperty
  a_an_link: assert property (p_an_link) else $error("link up in restart");
  property p_speed; !$past(rst) && !$past(media_mode) |-> speed_sel == $past(net_speed); endproperty
  a_speed: assert property (p_speed) else $error("speed not tracking");
  property p_an_change; $changed(autoneg_enable) |-> ##[0:2] autoneg_restart; endproperty
  a_an_change: assert property (p_an_change) else $error("no restart on change");
  property p_an_min; $rose(autoneg_restart) |-> s_an_run; endproperty
  a_an_min: assert property (p_an_min) else $error("restart too short");
  property p_an_end; autoneg_restart |-> ##[1:40] !autoneg_restart; endproperty
  a_an_end: assert property (p_an_end) else $error("restart stuck");
  property p_swr_lb; $rose(port_sw_reset) |-> ##[0:1] !loopback_en; endproperty
  a_swr_lb: assert property (p_swr_lb) else $error("loopback kept");
  property p_swr_an; $fell(port_sw_reset) |-> ##[0:2] autoneg_restart; endproperty
  a_swr_an: assert property (p_swr_an) else $error("no restart after reset");
endmodule : serial_port_control_checker

//--- test/mac_line_model.sv
// Purpose: Far-side source of receive data on the serial line
// Assumes: Same clock as the bank
// Notes: Idle data toggles so stale bytes never match
`timescale 1ns/1ns
module mac_line_model (
  input wire logic ref_clk,
  input wire logic send,
  output logic [7:0] line_rxd = 8'h00,
  output logic line_rx_dv = 1'b0
);
  logic [7:0] cnt_reg = 8'h00;
  always @(posedge ref_clk) begin
    cnt_reg <= cnt_reg + 8'h01;
    line_rx_dv <= send;
    line_rxd <= send ? cnt_reg : ~line_rxd;
  end
endmodule : mac_line_model

//--- test/serial_port_control_bench.sv
// Purpose: Self-checking bench of the serial port control bank
// Assumes: Straps high with mode strap 101
// Notes: Bus tasks wait on the handshakes; a cycle ceiling cuts hangs
`timescale 1ns/1ns
module serial_port_control_bench;
  logic ref_clk = 1'b0, rst = 1'b1;
  logic [11:0] s_axil_awaddr = 12'h000, s_axil_araddr = 12'h000;
  logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata;
  logic [3:0] s_axil_wstrb = 4'hf;
  logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0, s_axil_awready;
  logic s_axil_arvalid = 1'b0, s_axil_rready = 1'b0, s_axil_wready, s_axil_bvalid;
  logic s_axil_arready, s_axil_rvalid, port_sw_reset, link_enable, loopback_en;
  logic [1:0] s_axil_bresp, s_axil_rresp, speed_sel, net_speed = 2'h2;
  logic autoneg_strap = 1'b1, powerdown_strap = 1'b1, tx_en = 1'b1, mac_send = 1'b0;
  logic [2:0] mode_strap = 3'h5;
  logic [7:0] txd = 8'h5a, line_rxd, rxd, prev_line;
  logic line_rx_dv, rx_dv, port_powerdown, autoneg_enable, autoneg_restart, media_mode;
  int err_count = 0, total_checks = 0, cycles = 0;
  serial_port_control serial_port_control_i (.*);
  mac_line_model mac_line_model_i (.ref_clk, .send(mac_send), .line_rxd, .line_rx_dv);
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    prev_line <= line_rxd;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic cb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask : cb
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge ref_clk);
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_wstrb <= s;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axil_awready) s_axil_awvalid <= 1'b0;
      if (s_axil_wready) s_axil_wvalid <= 1'b0;
    end while (!s_axil_bvalid);
    chk({30'h0, s_axil_bresp}, {30'h0, a > 12'h008 ? serial_port_pkg::RESP_DECERR : serial_port_pkg::RESP_OKAY});
    s_axil_bready <= 1'b0;
  endtask : wr
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axil_arready) s_axil_arvalid <= 1'b0;
    end while (!s_axil_rvalid);
    chk(s_axil_rdata, e);
    chk({30'h0, s_axil_rresp}, {30'h0, a > 12'h008 ? serial_port_pkg::RESP_DECERR : serial_port_pkg::RESP_OKAY});
    s_axil_rready <= 1'b0;
  endtask : rc
  task automatic t_boot();
    repeat (10) @(posedge ref_clk);
    cb(autoneg_restart, 1'b1);
    repeat (20) @(posedge ref_clk);
    rc(12'h000, 32'h1940);
    cb(link_enable, 1'b0);
    rc(12'h00c, 32'h0);
    wr(12'h00c, 32'hffff, 4'hf);
  endtask : t_boot
  task automatic t_an();
    wr(12'h000, 32'h05bf, 4'hf);
    rc(12'h000, 32'h0340);
    repeat (15) @(posedge ref_clk);
    rc(12'h000, 32'h0140);
    cb(link_enable, 1'b1);
    wr(12'h000, 32'h0200, 4'hf);
    @(negedge ref_clk) cb(autoneg_restart, 1'b1);
    repeat (12) @(posedge ref_clk);
  endtask : t_an
  task automatic t_speed();
    wr(12'h004, 32'h1, 4'hf);
    cb(media_mode, 1'b1);
    wr(12'h000, 32'h2000, 4'hf);
    rc(12'h000, 32'h2100);
    net_speed <= 2'h1;
    wr(12'h000, 32'h0040, 4'hf);
    rc(12'h000, 32'h0140);
    wr(12'h004, 32'h0, 4'hf);
    wr(12'h000, 32'h0040, 4'hf);
    rc(12'h000, 32'h2100);
  endtask : t_speed
  task automatic t_loop();
    mac_send <= 1'b1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk) chk({24'h0, rxd}, {24'h0, prev_line});
    wr(12'h000, 32'h4000, 4'hf);
    txd <= 8'ha5;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk) chk({24'h0, rxd}, 32'ha5);
    cb(link_enable, 1'b0);
  endtask : t_loop
  task automatic t_swr();
    wr(12'h000, 32'h8000, 4'h1);
    cb(port_sw_reset, 1'b0);
    wr(12'h000, 32'h8000, 4'hf);
    rc(12'h000, 32'ha100);
    for (int n = 0; n < 40 && port_sw_reset !== 1'b0; n++) @(posedge ref_clk);
    rc(12'h000, 32'h2300);
  endtask : t_swr
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    t_boot();
    t_an();
    t_speed();
    t_loop();
    t_swr();
    give_verdict();
  end
endmodule : serial_port_control_bench
bind serial_port_control serial_port_control_checker serial_port_control_checker_i (.*);
